//--- design/ccsd_decoder.sv
// Purpose: serial command decoder behind the host serial port
// Assumes: sck, cs_n, si asynchronous; sck far slower than clk
// Notes:   register file lives outside; reads return same cycle
`timescale 1ns/1ps
module ccsd_decoder
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              spi_sck,
   input  wire logic              spi_cs_n,
   input  wire logic              spi_si,
   output logic                   spi_so,
   output logic                   spi_so_oe_n,
   output logic [7:0]             reg_rd_addr,
   input  wire logic [7:0]        reg_rdata,
   input  wire logic              reg_bitmod_ok,
   input  wire logic [7:0]        status_byte,
   input  wire logic [7:0]        rx_status_byte,
   output ccsd_pkg::ccsd_wr_t     reg_wr,
   output logic [2:0]             tx_send_request_bit,
   output logic [1:0]             rx_buffer_full_flag_clr,
   output logic                   soft_reset
);
   import ccsd_pkg::*;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   // buffer-load pointer target
   function automatic logic [7:0] txb_addr(input logic [2:0] abc);
      case (abc)
         3'h0:    txb_addr = TX0_ID_START;
         3'h1:    txb_addr = TX0_PL_START;
         3'h2:    txb_addr = TX1_ID_START;
         3'h3:    txb_addr = TX1_PL_START;
         3'h4:    txb_addr = TX2_ID_START;
         default: txb_addr = TX2_PL_START;
      endcase
   endfunction

   // receive-buffer pointer target
   function automatic logic [7:0] rxb_addr(input logic [1:0] nm);
      case (nm)
         2'h0:    rxb_addr = RX0_ID_START;
         2'h1:    rxb_addr = RX0_PL_START;
         2'h2:    rxb_addr = RX1_ID_START;
         default: rxb_addr = RX1_PL_START;
      endcase
   endfunction

   // masked merge of old and new byte
   function automatic logic [7:0] bm_merge(
      input logic [7:0] old,
      input logic [7:0] msk,
      input logic [7:0] dat,
      input logic       ok);
      logic [7:0] m;
      m = ok ? msk : MASK_ALL;
      bm_merge = (old & ~m) | (dat & m);
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic        sck_m_r;
   logic        sck_s_r;
   logic        sck_d_r;
   logic        csn_m_r;
   logic        csn_s_r;
   logic        csn_d_r;
   logic        si_m_r;
   logic        si_s_r;

   // two flops per pin, third on sck and cs_n for edge detect
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sck_m_r <= 1'b0;
         sck_s_r <= 1'b0;
         sck_d_r <= 1'b0;
         csn_m_r <= 1'b1;
         csn_s_r <= 1'b1;
         csn_d_r <= 1'b1;
         si_m_r  <= 1'b0;
         si_s_r  <= 1'b0;
      end
      else if (ce)
      begin
         sck_m_r <= spi_sck;
         sck_s_r <= sck_m_r;
         sck_d_r <= sck_s_r;
         csn_m_r <= spi_cs_n;
         csn_s_r <= csn_m_r;
         csn_d_r <= csn_s_r;
         si_m_r  <= spi_si;
         si_s_r  <= si_m_r;
      end
   end

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   ccsd_state_t st_r;
   ccsd_state_t st_nxt;
   logic [2:0]  cnt_r;
   logic [6:0]  sh_r;
   logic [7:0]  ptr_r;
   logic [7:0]  mask_r;
   logic [7:0]  tx_sh_r;
   logic [7:0]  rxs_r;
   logic        load_r;
   logic        rxrd_r;
   logic        rxn_r;
   logic        so_r;
   logic        so_oe_n_r;
   ccsd_wr_t    wr_r;
   logic [2:0]  rts_r;
   logic [1:0]  rxclr_r;
   logic        srst_r;
   logic        rxs_load_first;
   logic        rxs_seen_r;

   wire       active    = !csn_s_r;
   wire       cs_rise   = csn_s_r && !csn_d_r;
   wire       sck_rise  = sck_s_r && !sck_d_r;
   wire       sck_fall  = !sck_s_r && sck_d_r;
   wire [7:0] rx_byte   = {sh_r, si_s_r};
   // byte only counts on its eighth rising edge
   wire       byte_done = active && sck_rise && cnt_r == BIT_LAST;
   wire       cmd_done  = byte_done && st_r == S_CMD;
   wire       is_ltx    = rx_byte[7:3] == OP_LTX_HI
                          && rx_byte[2:0] < 3'h6;
   wire       is_rts    = rx_byte[7:3] == OP_RTS_HI;
   wire       is_rxr    = rx_byte[7:3] == OP_RXR_HI && !rx_byte[0];
   wire       out_st    = st_r == S_RDATA || st_r == S_STAT
                          || st_r == S_RXST;
   wire [7:0] bm_data   = bm_merge(reg_rdata, mask_r, rx_byte,
                                   reg_bitmod_ok);

   // next state after a complete byte
   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         // first byte is always the opcode
         S_CMD:
         begin
            if (rx_byte == OP_READ)
               st_nxt = S_RADDR;
            else if (rx_byte == OP_WRITE)
               st_nxt = S_WADDR;
            else if (rx_byte == OP_BITMOD)
               st_nxt = S_BADDR;
            else if (rx_byte == OP_RDSTAT)
               st_nxt = S_STAT;
            else if (rx_byte == OP_RXSTAT)
               st_nxt = S_RXST;
            else if (is_ltx)
               st_nxt = S_WDATA;
            else if (is_rxr)
               st_nxt = S_RDATA;
            else
               st_nxt = S_IGN; // reset, send request, unknown
         end
         S_RADDR: st_nxt = S_RDATA;
         S_WADDR: st_nxt = S_WDATA;
         S_BADDR: st_nxt = S_MASK;
         S_MASK:  st_nxt = S_BDATA;
         S_BDATA: st_nxt = S_IGN;
         S_RDATA: st_nxt = S_RDATA;
         S_WDATA: st_nxt = S_WDATA;
         S_STAT:  st_nxt = S_STAT;
         S_RXST:  st_nxt = S_RXST;
         S_IGN:   st_nxt = S_IGN;
         default: st_nxt = S_IGN;
      endcase
   end

   // bit counter, input shifter, state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_r  <= S_CMD;
         cnt_r <= 3'h0;
         sh_r  <= 7'h00;
      end
      else if (ce)
      begin
         if (!active)
         begin
            st_r  <= S_CMD;
            cnt_r <= 3'h0;
         end
         else if (sck_rise)
         begin
            cnt_r <= cnt_r + 3'h1;
            sh_r  <= rx_byte[6:0];
            if (cnt_r == BIT_LAST)
               st_r <= st_nxt;
         end
      end
   end

   // address pointer and mask capture
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ptr_r  <= PTR_RST;
         mask_r <= MASK_ALL;
      end
      else if (ce)
      begin
         if (cmd_done && is_ltx)
            ptr_r <= txb_addr(rx_byte[2:0]);
         else if (cmd_done && is_rxr)
            ptr_r <= rxb_addr(rx_byte[2:1]);
         else if (byte_done && (st_r == S_RADDR
                  || st_r == S_WADDR || st_r == S_BADDR))
            ptr_r <= rx_byte;
         else if (load_r && st_r == S_RDATA)
            ptr_r <= ptr_r + 8'h01;
         else if (byte_done && st_r == S_WDATA)
            ptr_r <= ptr_r + 8'h01;
         if (byte_done && st_r == S_MASK)
            mask_r <= rx_byte;
      end
   end

   // ---------------------------------------------------------------
   // output path
   // ---------------------------------------------------------------
   // load next outgoing byte, then shift on falling sck
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         load_r    <= 1'b0;
         tx_sh_r   <= 8'h00;
         rxs_r     <= 8'h00;
         so_r      <= 1'b0;
         so_oe_n_r <= 1'b1;
      end
      else if (ce)
      begin
         load_r    <= byte_done && (st_nxt == S_RDATA
                      || st_nxt == S_STAT || st_nxt == S_RXST);
         so_oe_n_r <= !(active && out_st);
         if (load_r)
         begin
            if (st_r == S_RDATA)
               tx_sh_r <= reg_rdata;
            else if (st_r == S_STAT)
               tx_sh_r <= status_byte;
            else if (cnt_r == 3'h0 && rxs_load_first)
            begin
               tx_sh_r <= rx_status_byte;
               rxs_r   <= rx_status_byte;
            end
            else
               tx_sh_r <= rxs_r;
         end
         else if (active && out_st && sck_fall)
         begin
            so_r    <= tx_sh_r[7];
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
         end
         else if (!active)
            so_r <= 1'b0;
      end
   end

   // marks the first receive-status byte of a selection
   assign rxs_load_first = !rxs_seen_r;

   always_ff @(posedge clk)
   begin
      if (rst)
         rxs_seen_r <= 1'b0;
      else if (ce)
      begin
         if (!active)
            rxs_seen_r <= 1'b0;
         else if (load_r && st_r == S_RXST)
            rxs_seen_r <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // side effects
   // ---------------------------------------------------------------
   // writes, send requests, flag clears, soft reset
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_r    <= '0;
         rts_r   <= 3'h0;
         rxclr_r <= 2'h0;
         srst_r  <= 1'b0;
         rxrd_r  <= 1'b0;
         rxn_r   <= 1'b0;
      end
      else if (ce)
      begin
         wr_r.en <= 1'b0;
         // plain write of each complete byte
         if (byte_done && st_r == S_WDATA)
         begin
            wr_r.en   <= 1'b1;
            wr_r.addr <= ptr_r;
            wr_r.data <= rx_byte;
         end
         // masked merge, full mask if not allowed
         else if (byte_done && st_r == S_BDATA)
         begin
            wr_r.en   <= 1'b1;
            wr_r.addr <= ptr_r;
            wr_r.data <= bm_data;
         end
         rts_r  <= (cmd_done && is_rts) ? rx_byte[2:0] : 3'h0;
         // reset pulse to the register file
         srst_r <= cmd_done && rx_byte == OP_RESET;
         // clear read buffer's flag on deselect
         rxclr_r <= 2'h0;
         if (cs_rise && rxrd_r)
            rxclr_r <= rxn_r ? 2'h2 : 2'h1;
         if (cs_rise)
            rxrd_r <= 1'b0;
         else if (cmd_done && is_rxr)
         begin
            rxrd_r <= 1'b1;
            rxn_r  <= rx_byte[2];
         end
      end
   end

   assign spi_so                  = so_r;
   assign spi_so_oe_n             = so_oe_n_r;
   assign reg_rd_addr             = ptr_r;
   assign reg_wr                  = wr_r;
   assign tx_send_request_bit     = rts_r;
   assign rx_buffer_full_flag_clr = rxclr_r;
   assign soft_reset              = srst_r;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);

   a_ltx_pointer: assert property (cmd_done && is_ltx ##1 ce
      |-> ptr_r == txb_addr($past(rx_byte[2:0])))
      else $error("buffer-load pointer wrong");
   a_rts_select: assert property (cmd_done && is_rts ##1 ce
      |-> rts_r == $past(rx_byte[2:0]))
      else $error("send request bits wrong");
   a_rts_empty: assert property (cmd_done && rx_byte == {OP_RTS_HI, 3'h0}
      |=> rts_r == 3'h0 ##1 rts_r == 3'h0)
      else $error("empty send request acted");
   a_bm_merge: assert property (byte_done && st_r == S_BDATA && reg_bitmod_ok ##1 ce
      |-> wr_r.en && wr_r.data == (($past(reg_rdata) & ~$past(mask_r))
          | ($past(rx_byte) & $past(mask_r))))
      else $error("masked write wrong");
   a_bm_full: assert property (byte_done && st_r == S_BDATA && !reg_bitmod_ok ##1 ce
      |-> wr_r.en && wr_r.data == $past(rx_byte))
      else $error("full-mask write wrong");
   a_rd_advance: assert property (load_r && st_r == S_RDATA ##1 ce
      |-> ptr_r == $past(ptr_r) + 8'h01)
      else $error("read pointer did not advance");
   a_rx_clear: assert property (cs_rise && rxrd_r && rxn_r
      |=> rxclr_r == 2'h2 ##1 rxclr_r == 2'h0)
      else $error("receive flag clear wrong");
   a_stat_load: assert property (load_r && st_r == S_STAT ##1 ce
      |-> tx_sh_r == $past(status_byte))
      else $error("status byte not loaded");
   a_ign_quiet: assert property (st_r == S_IGN && active
      |=> !wr_r.en && so_oe_n_r)
      else $error("ignored command had effect");
   a_reset_pulse: assert property (cmd_done && rx_byte == OP_RESET
      |=> srst_r ##1 !srst_r)
      else $error("reset pulse wrong");

   c_write: cover property (byte_done && st_r == S_WDATA);
   c_bitmod: cover property (byte_done && st_r == S_BDATA);
   c_rxread: cover property (cs_rise && rxrd_r);
   c_status2: cover property (load_r && st_r == S_STAT && rxs_seen_r == 1'b0 ##[1:400]
                              load_r && st_r == S_STAT);
endmodule

//--- design/ccsd_pkg.sv
// Purpose: constants and types for the serial command decoder
// Assumes: one register byte per address, 8-bit address space
// Notes:   opcode patterns, pointer targets, states, write carrier
// Summary of operation
// - buffer-load opcode sets pointer, no address byte
// - abc 000/010/100 pick buffer id start
// - abc 001/011/101 pick buffer payload start
// - send-request sets each selected buffer's bit
// - send-request with 000 does nothing
// - status poll returns one status byte
// - status byte repeats while clocks continue
// - status bits match their home registers
// - receive-status returns filter and frame type
// - receive-status repeats the identical byte
// - masked update changes only mask-one bits
// - non-modifiable register forces mask all ones
// - reset opcode restores defaults, configuration mode
// - read opcode plus address streams registers out
// - write opcode plus address stores data
// - receive-buffer read sets pointer, streams data
// - chip select rise clears read buffer flag
// - first byte after select is opcode
// - pointer advances after each byte read
// - byte commits on last bit; partial discarded
// - sample on rising, drive on falling edge
package ccsd_pkg;

   // ---------------------------------------------------------------
   // opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_RESET  = 8'hc0;
   localparam logic [7:0] OP_READ   = 8'h03;
   localparam logic [7:0] OP_WRITE  = 8'h02;
   localparam logic [7:0] OP_BITMOD = 8'h05;
   localparam logic [7:0] OP_RDSTAT = 8'ha0;
   localparam logic [7:0] OP_RXSTAT = 8'hb0;
   localparam logic [4:0] OP_LTX_HI = 5'h08; // 0100 0abc
   localparam logic [4:0] OP_RTS_HI = 5'h10; // 1000 0nnn
   localparam logic [4:0] OP_RXR_HI = 5'h12; // 1001 0nm0

   // ---------------------------------------------------------------
   // pointer targets
   // ---------------------------------------------------------------
   localparam logic [7:0] TX0_ID_START = 8'h31;
   localparam logic [7:0] TX0_PL_START = 8'h36;
   localparam logic [7:0] TX1_ID_START = 8'h41;
   localparam logic [7:0] TX1_PL_START = 8'h46;
   localparam logic [7:0] TX2_ID_START = 8'h51;
   localparam logic [7:0] TX2_PL_START = 8'h56;
   localparam logic [7:0] RX0_ID_START = 8'h61;
   localparam logic [7:0] RX0_PL_START = 8'h66;
   localparam logic [7:0] RX1_ID_START = 8'h71;
   localparam logic [7:0] RX1_PL_START = 8'h76;

   // ---------------------------------------------------------------
   // reset values and field constants
   // ---------------------------------------------------------------
   localparam logic [7:0] MASK_ALL  = 8'hff;
   localparam logic [7:0] PTR_RST   = 8'h00;
   localparam logic [2:0] BIT_LAST  = 3'h7;

   typedef enum logic [10:0] {
      S_CMD   = 11'h001,
      S_RADDR = 11'h002,
      S_WADDR = 11'h004,
      S_BADDR = 11'h008,
      S_RDATA = 11'h010,
      S_WDATA = 11'h020,
      S_MASK  = 11'h040,
      S_BDATA = 11'h080,
      S_STAT  = 11'h100,
      S_RXST  = 11'h200,
      S_IGN   = 11'h400
   } ccsd_state_t;

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } ccsd_wr_t;

endpackage

//--- verification/ccsd_host_model.sv
// Purpose: host serial master model for the command decoder
// Assumes: pins change only just after clk rising edges
// Notes:   64 ns serial period; released data line shows inverse
`timescale 1ns/1ps
module ccsd_host_model
(
   input  wire logic clk,
   input  wire logic so_pin,
   output logic      sck,
   output logic      cs_n,
   output logic      si
);

   real  target;
   logic cpol;

   // ---------------------------------------------------------------
   // idle pins
   // ---------------------------------------------------------------
   // deselected, clock still
   initial
   begin
      sck    = 1'b0;
      cs_n   = 1'b1;
      si     = 1'b0;
      cpol   = 1'b0;
      target = 0.0;
   end

   // ---------------------------------------------------------------
   // frame tasks
   // ---------------------------------------------------------------
   // half serial period on the clk grid, 32 ns average
   task automatic half_wait();
      target = target + 32.0;
      while ($realtime < target)
      begin
         @(posedge clk);
      end
   endtask

   task automatic select(input logic mode);
      @(posedge clk);
      cpol = mode;
      sck  <= mode;
      repeat (3) @(posedge clk);
      cs_n   <= 1'b0;
      target = $realtime;
      half_wait();
   endtask

   // bit out on fall, sampled by device on rise; so read at rise
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--)
      begin
         if (cpol)
            sck <= 1'b0;
         si <= tx[i];
         half_wait();
         rx[i] = so_pin;
         sck   <= 1'b1;
         half_wait();
         if (!cpol)
            sck <= 1'b0;
      end
   endtask

   // deselect ends command; released data line inverted
   task automatic deselect();
      half_wait();
      cs_n <= 1'b1;
      si   <= ~si;
      repeat (12) @(posedge clk);
   endtask

endmodule

//--- verification/tb_top.sv
// Purpose: self-checking bench for the serial command decoder
// Assumes: register file modelled here, bit-modify only at 8'h2c
// Notes:   host model drives serial pins, bench judges outputs
`timescale 1ns/1ps
module tb_top;
   import ccsd_pkg::*;

   logic             clk;
   logic             rst;
   logic             ce;
   wire logic        sck;
   wire logic        cs_n;
   wire logic        si;
   logic             spi_so;
   logic             so_oe_n;
   logic [7:0]       reg_rd_addr;
   logic [7:0]       reg_rdata;
   logic             reg_bitmod_ok;
   logic [7:0]       status_byte;
   logic [7:0]       rx_status_byte;
   ccsd_wr_t         reg_wr;
   logic [2:0]       tx_req;
   logic [1:0]       rx_clr;
   logic             soft_reset;
   wire logic        so_pin;
   logic [7:0]       mem [256];
   logic [7:0]       n_wr;
   logic [2:0]       send_acc;
   logic [1:0]       clr_acc;
   logic [7:0]       rst_seen;
   logic             oe_seen;
   int               n_mismatch;
   int               compares;
   int               cycles;

   // ---------------------------------------------------------------
   // clock, pins, register file
   // ---------------------------------------------------------------
   // 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // so pin floats unless enabled
   assign so_pin        = so_oe_n ? 1'bz : spi_so;
   assign reg_rdata     = mem[reg_rd_addr];
   assign reg_bitmod_ok = (reg_rd_addr == 8'h2c);

   // register writes, pulse tally, timeout
   always @(posedge clk)
   begin
      if (reg_wr.en === 1'b1)
      begin
         mem[reg_wr.addr] <= reg_wr.data;
         n_wr = n_wr + 8'h01;
      end
      send_acc = send_acc | tx_req;
      clr_acc  = clr_acc | rx_clr;
      rst_seen = rst_seen + {7'h00, soft_reset};
      if (so_oe_n === 1'b0)
         oe_seen = 1'b1;
      cycles++;
      if (cycles == 40000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   ccsd_host_model i_host (.clk(clk), .so_pin(so_pin), .sck(sck), .cs_n(cs_n), .si(si));

   ccsd_decoder i_dut
   (
      .clk                     (clk),
      .rst                     (rst),
      .ce                      (ce),
      .spi_sck                 (sck),
      .spi_cs_n                (cs_n),
      .spi_si                  (si),
      .spi_so                  (spi_so),
      .spi_so_oe_n             (so_oe_n),
      .reg_rd_addr             (reg_rd_addr),
      .reg_rdata               (reg_rdata),
      .reg_bitmod_ok           (reg_bitmod_ok),
      .status_byte             (status_byte),
      .rx_status_byte          (rx_status_byte),
      .reg_wr                  (reg_wr),
      .tx_send_request_bit     (tx_req),
      .rx_buffer_full_flag_clr (rx_clr),
      .soft_reset              (soft_reset)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic clr_tally();
      n_wr     = 8'h00;
      send_acc = 3'h0;
      clr_acc  = 2'h0;
      rst_seen = 8'h00;
      oe_seen  = 1'b0;
   endtask

   // one whole frame of bytes, returns bytes seen on so
   task automatic run(input logic m, input logic [7:0] q [$], output logic [7:0] r [$]);
      logic [7:0] b;
      r = {};
      i_host.select(m);
      foreach (q[k])
      begin
         i_host.xfer(q[k], 8, b);
         r.push_back(b);
      end
      i_host.deselect();
   endtask

   task automatic give_verdict();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_write();
      logic [7:0] r [$];
      logic [7:0] b;
      logic [7:0] old;
      run(1'b0, {8'h02, 8'h2a, 8'h55, 8'h66}, r);
      chk(mem[8'h2a], 8'h55, "write first");
      chk(mem[8'h2b], 8'h66, "write next");
      old = mem[8'h21];
      i_host.select(1'b0);
      i_host.xfer(8'h02, 8, b);
      i_host.xfer(8'h20, 8, b);
      i_host.xfer(8'h11, 8, b);
      i_host.xfer(8'h77, 5, b);
      i_host.deselect();
      chk(mem[8'h20], 8'h11, "whole byte kept");
      chk(mem[8'h21], old, "partial byte");
   endtask

   task automatic t_read();
      logic [7:0] r [$];
      for (int m = 0; m < 2; m++)
      begin
         clr_tally();
         run(1'(m), {8'h03, 8'h2a, 8'h00, 8'h00}, r);
         chk(r[2], 8'h55, "read first");
         chk(r[3], 8'h66, "read next");
         chk({7'h00, oe_seen}, 8'h01, "output enabled");
      end
   endtask

   task automatic t_load();
      logic [7:0] r [$];
      logic [7:0] tgt [6];
      tgt = '{TX0_ID_START, TX0_PL_START, TX1_ID_START, TX1_PL_START,
              TX2_ID_START, TX2_PL_START};
      for (int a = 0; a < 6; a++)
      begin
         run(1'b0, {8'h40 | 8'(a), 8'ha0 + 8'(a)}, r);
         chk(mem[tgt[a]], 8'ha0 + 8'(a), "load tx");
      end
      clr_tally();
      run(1'b0, {8'h46, 8'h12}, r);
      chk(n_wr, 8'h00, "load tx code 110");
   endtask

   task automatic t_rts();
      logic [7:0] r [$];
      for (int n = 0; n < 8; n++)
      begin
         clr_tally();
         run(1'b0, {8'h80 | 8'(n)}, r);
         chk({5'h00, send_acc}, 8'(n), "send request");
      end
   endtask

   task automatic t_status();
      logic [7:0] r [$];
      logic [7:0] b1;
      logic [7:0] b2;
      status_byte <= 8'ha5;
      run(1'b0, {8'ha0, 8'h00, 8'h00}, r);
      chk(r[1], 8'ha5, "status");
      chk(r[2], 8'ha5, "status again");
      rx_status_byte <= 8'h3c;
      i_host.select(1'b1);
      i_host.xfer(8'hb0, 8, b1);
      i_host.xfer(8'h00, 8, b1);
      rx_status_byte <= 8'hc3;
      i_host.xfer(8'h00, 8, b2);
      i_host.deselect();
      chk(b1, 8'h3c, "rx status");
      chk(b2, 8'h3c, "rx status again");
   endtask

   task automatic t_bitmod();
      logic [7:0] r [$];
      run(1'b0, {8'h02, 8'h2c, 8'hf0}, r);
      clr_tally();
      run(1'b0, {8'h05, 8'h2c, 8'h3c, 8'haa, 8'h11}, r);
      chk(mem[8'h2c], 8'he8, "masked update");
      chk(n_wr, 8'h01, "bytes after data");
      run(1'b0, {8'h05, 8'h2a, 8'h0f, 8'ha0}, r);
      chk(mem[8'h2a], 8'ha0, "mask forced");
   endtask

   task automatic t_misc();
      logic [7:0] r [$];
      clr_tally();
      run(1'b0, {8'hc0}, r);
      chk(rst_seen, 8'h01, "soft reset");
      clr_tally();
      run(1'b0, {8'hff, 8'h02, 8'h2a, 8'h99}, r);
      chk(n_wr, 8'h00, "unknown opcode");
      chk({7'h00, oe_seen}, 8'h00, "no output");
   endtask

   task automatic t_rxread();
      logic [7:0] r [$];
      logic [7:0] rxt [4];
      logic [7:0] exp;
      rxt = '{RX0_ID_START, RX0_PL_START, RX1_ID_START, RX1_PL_START};
      for (int nm = 0; nm < 4; nm++)
      begin
         exp = mem[rxt[nm]];
         clr_tally();
         run(1'b0, {8'h90 | 8'(nm << 1), 8'h00}, r);
         chk(r[1], exp, "rx buffer read");
         chk({6'h00, clr_acc}, 8'(1 << (nm >> 1)), "flag clear");
      end
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst            = 1'b1;
      ce             = 1'b1;
      status_byte    = 8'h00;
      rx_status_byte = 8'h00;
      n_mismatch     = 0;
      compares       = 0;
      cycles         = 0;
      clr_tally();
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i) ^ 8'h5a;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      t_write();
      t_read();
      t_load();
      t_rts();
      t_status();
      t_bitmod();
      t_misc();
      t_rxread();
      give_verdict();
   end

endmodule
